// file: hw/ctu_edge_current_ctrl.sv
// Edge channel and current source control registers of the charge time unit
module ctu_edge_current_ctrl
    import ctu_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    // Register port
    input  wire logic [1:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [15:0] RDATA_O,
    // Edge sources
    input  wire logic        TIMER_I,
    input  wire logic        COMPARE_I,
    input  wire logic        PIN_ONE_I,
    input  wire logic        PIN_TWO_I,
    input  wire logic        COMPARATOR_I,
    // Edge status towards the analog unit
    output logic             FIRST_EDGE_OCCURRED_O,
    output logic             SECOND_EDGE_OCCURRED_O,
    // Current source control
    output logic      [5:0]  CURRENT_TRIM_O,
    output logic      [1:0]  CURRENT_RANGE_O,
    output logic      [6:0]  TRIM_PERCENT_O,
    output logic             TRIM_NEGATIVE_O
);
    logic [15:0] edge_cfg;
    logic [15:0] current_cfg;
    logic        first_edge_occurred;
    logic        second_edge_occurred;
    logic        first_hit;
    logic        second_hit;
    logic        wr_edge;
    logic        wr_current;
    logic [15:0] edge_view;
    logic [5:0]  trim_mag;

    assign wr_edge    = WR_I && (ADDR_I == ADDR_EDGE_CONTROL);
    assign wr_current = WR_I && (ADDR_I == ADDR_CURRENT_CONTROL);

    // Edge configuration fields, flags held separately
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            edge_cfg <= EDGE_RESET;
        end else if (CE_I && wr_edge) begin
            edge_cfg <= WDATA_I & EDGE_IMPL_MASK;
        end
    end

    // Current configuration register
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            current_cfg <= CURRENT_RESET;
        end else if (CE_I && wr_current) begin
            current_cfg <= WDATA_I & CURRENT_IMPL_MASK;
        end
    end

    // Both channels share one module; the flag bit selects the code table
    ctu_edge_channel u_first (
        .clk_i        (CLK_SYS_I),
        .rst_i        (RST_I),
        .ce_i         (CE_I),
        .is_second_i  (1'b0),
        .source_i     (edge_cfg[POS_FIRST_SRC +: 4]),
        .polarity_i   (edge_cfg[POS_FIRST_POL]),
        .mode_i       (edge_cfg[POS_FIRST_MODE]),
        .timer_i      (TIMER_I),
        .compare_i    (COMPARE_I),
        .pin_one_i    (PIN_ONE_I),
        .pin_two_i    (PIN_TWO_I),
        .comparator_i (COMPARATOR_I),
        .hit_o        (first_hit)
    );
    ctu_edge_channel u_second (
        .clk_i        (CLK_SYS_I),
        .rst_i        (RST_I),
        .ce_i         (CE_I),
        .is_second_i  (1'b1),
        .source_i     (edge_cfg[POS_SECOND_SRC +: 4]),
        .polarity_i   (edge_cfg[POS_SECOND_POL]),
        .mode_i       (edge_cfg[POS_SECOND_MODE]),
        .timer_i      (TIMER_I),
        .compare_i    (COMPARE_I),
        .pin_one_i    (PIN_ONE_I),
        .pin_two_i    (PIN_TWO_I),
        .comparator_i (COMPARATOR_I),
        .hit_o        (second_hit)
    );

    // First flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            first_edge_occurred <= 1'b0;
        end else if (CE_I) begin
            if (first_hit) begin
                first_edge_occurred <= 1'b1;
            end else if (wr_edge) begin
                first_edge_occurred <= WDATA_I[POS_FIRST_OCC];
            end
        end
    end

    // Second flag, same priority as the first
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            second_edge_occurred <= 1'b0;
        end else if (CE_I) begin
            if (second_hit) begin
                second_edge_occurred <= 1'b1;
            end else if (wr_edge) begin
                second_edge_occurred <= WDATA_I[POS_SECOND_OCC];
            end
        end
    end

    // Readback view merges live flags into the edge register
    always_comb begin
        edge_view                 = edge_cfg & EDGE_IMPL_MASK;
        edge_view[POS_FIRST_OCC]  = first_edge_occurred;
        edge_view[POS_SECOND_OCC] = second_edge_occurred;
    end

    // Read data valid the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 16'h0000;
        end else if (CE_I && RD_I) begin
            unique case (ADDR_I)
                ADDR_EDGE_CONTROL:    RDATA_O <= edge_view;
                ADDR_CURRENT_CONTROL: RDATA_O <= current_cfg & CURRENT_IMPL_MASK;
                default:              RDATA_O <= 16'h0000;
            endcase
        end
    end

    assign FIRST_EDGE_OCCURRED_O  = first_edge_occurred;
    assign SECOND_EDGE_OCCURRED_O = second_edge_occurred;

    // Range code passes straight to the analog source; the thousand-times
    // code is not blocked here, software must keep it off the diode
    assign CURRENT_RANGE_O = current_cfg[POS_RANGE +: 2];
    assign CURRENT_TRIM_O  = current_cfg[POS_TRIM +: 6];

    // Trim decoded to percent change: magnitude times two, sign separate
    assign TRIM_NEGATIVE_O = CURRENT_TRIM_O[5];
    assign trim_mag        = CURRENT_TRIM_O[5] ? 6'(-CURRENT_TRIM_O) : CURRENT_TRIM_O;
    assign TRIM_PERCENT_O  = {trim_mag, 1'b0};
endmodule // ctu_edge_current_ctrl

// file: hw/ctu_pkg.sv
// Package for the charge time unit edge and current control block
package ctu_pkg;
    // Register addresses on the plain register port
    localparam logic [1:0]  ADDR_EDGE_CONTROL    = 2'h0;
    localparam logic [1:0]  ADDR_CURRENT_CONTROL = 2'h1;
    // Edge control field positions
    localparam int          POS_FIRST_MODE       = 15;
    localparam int          POS_FIRST_POL        = 14;
    localparam int          POS_FIRST_SRC        = 10;
    localparam int          POS_SECOND_OCC       = 9;
    localparam int          POS_FIRST_OCC        = 8;
    localparam int          POS_SECOND_MODE      = 7;
    localparam int          POS_SECOND_POL       = 6;
    localparam int          POS_SECOND_SRC       = 2;
    // Current control field positions
    localparam int          POS_TRIM             = 10;
    localparam int          POS_RANGE            = 8;
    // Implemented bits of each register
    localparam logic [15:0] EDGE_IMPL_MASK       = 16'hFFFC;
    localparam logic [15:0] CURRENT_IMPL_MASK    = 16'hFF00;
    // Reset values
    localparam logic [15:0] EDGE_RESET           = 16'h0000;
    localparam logic [15:0] CURRENT_RESET        = 16'h0000;
    // Source selection codes
    typedef enum logic [3:0] {
        SRC1_TIMER   = 4'h0,
        SRC1_COMPARE = 4'h1,
        SRC1_PIN_TWO = 4'h2,
        SRC1_PIN_ONE = 4'h3
    } ctu_src1_type;
    typedef enum logic [3:0] {
        SRC2_COMPARE    = 4'h1,
        SRC2_PIN_ONE    = 4'h2,
        SRC2_PIN_TWO    = 4'h3,
        SRC2_COMPARATOR = 4'h4
    } ctu_src2_type;
    // Current range codes
    typedef enum logic [1:0] {
        RANGE_X1000 = 2'h0,
        RANGE_X1    = 2'h1,
        RANGE_X10   = 2'h2,
        RANGE_X100  = 2'h3
    } ctu_range_type;
endpackage

// file: hw/ctu_edge_channel.sv
// One edge channel: source mux, polarity, edge or level detection
module ctu_edge_channel
    import ctu_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Configuration
    input  wire logic       is_second_i,
    input  wire logic [3:0] source_i,
    input  wire logic       polarity_i,
    input  wire logic       mode_i,
    // Sources
    input  wire logic       timer_i,
    input  wire logic       compare_i,
    input  wire logic       pin_one_i,
    input  wire logic       pin_two_i,
    input  wire logic       comparator_i,
    // Result
    output logic            hit_o
);
    logic sel;
    logic known;
    logic active;
    logic prev;

    // Source decode; reserved codes select nothing and are marked unknown
    always_comb begin
        sel   = 1'b0;
        known = 1'b1;
        if (!is_second_i) begin
            unique case (source_i)
                SRC1_TIMER:   sel = timer_i;
                SRC1_COMPARE: sel = compare_i;
                SRC1_PIN_TWO: sel = pin_two_i;
                SRC1_PIN_ONE: sel = pin_one_i;
                default:      known = 1'b0;
            endcase
        end else begin
            unique case (source_i)
                SRC2_COMPARE:    sel = compare_i;
                SRC2_PIN_ONE:    sel = pin_one_i;
                SRC2_PIN_TWO:    sel = pin_two_i;
                SRC2_COMPARATOR: sel = comparator_i;
                default:         known = 1'b0;
            endcase
        end
    end

    // Polarity: falling response inverts the source; a reserved code must
    // never look like a held low level, so it is gated off entirely
    assign active = known & (polarity_i ? sel : ~sel);

    // Previous active level, for transition detection
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev <= 1'b0;
        end else if (ce_i) begin
            prev <= active;
        end
    end

    // Edge mode wants a new transition, level mode the level itself
    assign hit_o = mode_i ? (active & ~prev) : active;
endmodule // ctu_edge_channel

// file: test/ctu_checker.sv
// Port checker for the edge and current control block
module ctu_checker
    import ctu_pkg::*;
(
    // Clock, reset, register port
    input wire logic        CLK_SYS_I,
    input wire logic        RST_I,
    input wire logic        CE_I,
    input wire logic [1:0]  ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [15:0] RDATA_O,
    // Flags and current outputs
    input wire logic        FIRST_EDGE_OCCURRED_O,
    input wire logic        SECOND_EDGE_OCCURRED_O,
    input wire logic [5:0]  CURRENT_TRIM_O,
    input wire logic [1:0]  CURRENT_RANGE_O,
    input wire logic [6:0]  TRIM_PERCENT_O,
    input wire logic        TRIM_NEGATIVE_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] wd_q;
    logic [5:0]  mag;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    // Write data one cycle back, magnitude of the trim
    always_ff @(posedge CLK_SYS_I) wd_q <= WDATA_I;
    assign mag = CURRENT_TRIM_O[5] ? -CURRENT_TRIM_O : CURRENT_TRIM_O;
    // Accepted accesses
    sequence s_rd(a);
        RD_I && CE_I && ADDR_I == a;
    endsequence
    sequence s_wr(a);
        WR_I && CE_I && ADDR_I == a;
    endsequence
    a_edge_pad: assert property (s_rd(2'h0) |=> RDATA_O[1:0] == 2'h0)
        else $error("edge pad bits set");
    a_cur_pad: assert property (s_rd(2'h1) |=> RDATA_O[7:0] == 8'h00)
        else $error("current pad bits set");
    a_trim_takes: assert property (s_wr(2'h1) |=> CURRENT_TRIM_O == wd_q[15:10])
        else $error("trim not taken");
    a_range_takes: assert property (s_wr(2'h1) |=> CURRENT_RANGE_O == wd_q[9:8])
        else $error("range not taken");
    a_trim_scale: assert property (CURRENT_TRIM_O != 6'h20 |->
        TRIM_PERCENT_O == {mag, 1'b0} && TRIM_NEGATIVE_O == CURRENT_TRIM_O[5])
        else $error("trim decode wrong");
    a_first_set: assert property (s_wr(2'h0) ##0 WDATA_I[8] |=> FIRST_EDGE_OCCURRED_O)
        else $error("first flag not set");
    a_first_holds: assert property (FIRST_EDGE_OCCURRED_O && !(WR_I && ADDR_I == 2'h0)
        |=> FIRST_EDGE_OCCURRED_O) else $error("first flag lost");
    a_flag_read: assert property (s_rd(2'h0) |=> RDATA_O[9:8] ==
        {$past(SECOND_EDGE_OCCURRED_O), $past(FIRST_EDGE_OCCURRED_O)})
        else $error("flag readback wrong");
endmodule // ctu_checker

bind ctu_edge_current_ctrl ctu_checker ctu_checker_inst (
    .CLK_SYS_I, .RST_I, .CE_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .FIRST_EDGE_OCCURRED_O, .SECOND_EDGE_OCCURRED_O, .CURRENT_TRIM_O,
    .CURRENT_RANGE_O, .TRIM_PERCENT_O, .TRIM_NEGATIVE_O);

// file: test/ctu_source_model.sv
// Edge source model: timer, compare, two pins, comparator
module ctu_source_model (
    // Clock and commanded levels
    input  wire logic       clk_i,
    input  wire logic [4:0] level_i,
    // Source lines
    output logic            timer_o,
    output logic            compare_o,
    output logic            pin_one_o,
    output logic            pin_two_o,
    output logic            comparator_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Synchronous sources change only after an edge
    always_ff @(posedge clk_i)
        {comparator_o, pin_two_o, pin_one_o, compare_o, timer_o} <= level_i;
endmodule // ctu_source_model

// file: test/tb.sv
// Self-checking bench for the edge and current control block
module tb;
    import ctu_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, wr, rd, t, c, p1, p2, cm, f1, f2, ng;
    logic [1:0]  addr, rng;
    logic [15:0] wdata, rdata;
    logic [4:0]  lvl;
    logic [5:0]  trim;
    logic [6:0]  pct;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          m1 [4] = '{0, 1, 3, 2};
    logic [15:0] tv [4] = '{16'h05FF, 16'h7E5A, 16'hFC00, 16'h87A5};
    logic [6:0]  pv [4] = '{7'd2, 7'd62, 7'd2, 7'd62};
    // Design, edge sources
    ctu_edge_current_ctrl ctu_edge_current_ctrl_inst (.CLK_SYS_I(clk), .RST_I(rst),
        .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .TIMER_I(t), .COMPARE_I(c), .PIN_ONE_I(p1), .PIN_TWO_I(p2), .COMPARATOR_I(cm),
        .FIRST_EDGE_OCCURRED_O(f1), .SECOND_EDGE_OCCURRED_O(f2), .CURRENT_TRIM_O(trim),
        .CURRENT_RANGE_O(rng), .TRIM_PERCENT_O(pct), .TRIM_NEGATIVE_O(ng));
    ctu_source_model ctu_source_model_inst (.clk_i(clk), .level_i(lvl), .timer_o(t),
        .compare_o(c), .pin_one_o(p1), .pin_two_o(p2), .comparator_o(cm));
    // Compare got against expected exactly, count
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    // Write, then an idle edge so strobes never double up
    task automatic wr16(input logic [1:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read, data checked in the following cycle
    task automatic rc(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
        @(posedge clk);
    endtask
    task automatic conclude();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Watchdog, far beyond the roughly 116 cycles needed
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
    // Main sequence; inactive sources sit high
    initial begin
        {rst, wr, rd, addr, wdata, lvl} = {3'b100, 18'h0, 5'h1F};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(2'h0, 16'h0000, 16'hFFFF);
        rc(2'h1, 16'h0000, 16'hFFFF);
        chk({trim, rng, pct, ng}, 16'h0000);
        wr16(2'h2, 16'hFFFF);
        rc(2'h2, 16'h0000, 16'hFFFF);
        rc(2'h1, 16'h0000, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            wr16(2'h1, tv[i]); // bench drives no diode, any range is legal
            rc(2'h1, tv[i] & 16'hFF00, 16'hFFFF);
            chk({trim, rng, pct, ng}, {tv[i][15:8], pv[i], tv[i][15]});
        end
        wr16(2'h0, 16'hFFFF);
        rc(2'h0, 16'hFFFC, 16'hFFFF);
        wr16(2'h0, 16'hFCFC);
        rc(2'h0, 16'hFCFC, 16'hFFFF);
        // First channel, falling level, one source pulsed low
        for (int i = 0; i < 4; i++) begin
            wr16(2'h0, 16'(i) << 10 | 16'h0040);
            rc(2'h0, 16'(i) << 10 | 16'h0040, 16'hFFFF);
            lvl <= ~(5'h01 << m1[i]);
            @(posedge clk);
            lvl <= 5'h1F;
            // Flag lands one edge after the hit, read after it
            @(posedge clk);
            rc(2'h0, 16'(i) << 10 | 16'h0140, 16'hFFFF);
        end
        // Second channel; first parked on a reserved code
        for (int i = 1; i < 5; i++) begin
            wr16(2'h0, 16'h5000 | 16'(i) << 2);
            lvl <= ~(5'h01 << i);
            @(posedge clk);
            lvl <= 5'h1F;
            @(posedge clk);
            rc(2'h0, 16'h5200 | 16'(i) << 2, 16'hFFFF);
        end
        // Rising edge versus held level on pin one
        lvl <= 5'h1B;
        wr16(2'h0, 16'hCC40);
        rc(2'h0, 16'hCC40, 16'hFFFF);
        lvl <= 5'h1F;
        repeat (3) @(posedge clk);
        rc(2'h0, 16'hCD40, 16'hFFFF);
        wr16(2'h0, 16'hCC40);
        rc(2'h0, 16'hCC40, 16'hFFFF);
        wr16(2'h0, 16'h4C40);
        rc(2'h0, 16'h4D40, 16'hFFFF);
        conclude();
    end
endmodule // tb
